// ===== rtl/htt_trigger_tx.sv
// htt_trigger_tx: host-to-device trigger transmitter for one camera
// assumes a 50 MHz clock, an ack pulse from the receive side on the same
// clock, and an upconnection inserter that honours the packet strobe
`timescale 1ns/1ps
module htt_trigger_tx import htt_pkg::*; #(
	parameter int DEV_INDEX = 0,
	parameter int SEL_W = 4,
	parameter int FILT_W = 8,
	parameter int TO_W = 16,
	parameter int RS_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// register port
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	// trigger sources
	input wire logic cam_trigger,
	input wire logic [(1<<SEL_W)-1:0] gpio_lines,
	// low-speed upconnection
	input wire logic ack_in,
	output htt_pkt_t pkt,
	// events and status
	output logic ack_received_event,
	output logic packet_resent_event,
	output logic transaction_abort_event,
	output logic busy
);
	localparam logic [4:0] CHAR_LAST = 5'(CHAR_CYC - 1);
	localparam logic [3:0] PIPE_LAST = 4'(PIPE_CHARS - 1);
	localparam logic [3:0] MSG_LAST = 4'(MSG_CHARS - 1);
	localparam logic [5:0] US_LAST = 6'(US_CYC - 1);
	localparam logic [7:0] FINE_STEP = 8'(FINE_PER_CYC);
	localparam logic [3:0] DEV_ID = 4'(DEV_INDEX);

	// ----------------------------------------
	// software settings
	// ----------------------------------------
	htt_src_t src_sel_ff;
	htt_fmt_t fmt_ff;
	logic inv_ff;
	logic [SEL_W-1:0] line_sel_ff;
	logic [FILT_W-1:0] filt_ff;
	logic [TO_W-1:0] ack_to_ff;
	logic [RS_W-1:0] max_rs_ff;
	logic sw_level_ff;

	wire logic hit_ctrl = reg_addr == REG_CTRL;
	wire logic hit_filter = reg_addr == REG_FILTER;
	wire logic hit_ack_to = reg_addr == REG_ACK_TO;
	wire logic hit_max_rs = reg_addr == REG_MAX_RS;
	wire logic hit_status = reg_addr == REG_STATUS;
	wire logic hit_level = reg_addr == REG_LEVEL;
	wire logic hit_evcnt = reg_addr == REG_EVCNT;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			src_sel_ff <= SRC_NONE;
			fmt_ff <= FMT_PULSE;
			inv_ff <= 1'b0;
			line_sel_ff <= '0;
		end else if (reg_wr && hit_ctrl) begin
			src_sel_ff <= htt_src_t'(reg_wdata[CTRL_SRC_LSB +: 3]);
			fmt_ff <= htt_fmt_t'(reg_wdata[CTRL_FMT_LSB +: 2]);
			inv_ff <= reg_wdata[CTRL_INV_BIT];
			line_sel_ff <= reg_wdata[CTRL_LSEL_LSB +: SEL_W];
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			filt_ff <= FILT_W'(FILTER_RESET);
			ack_to_ff <= TO_W'(ACK_TO_RESET);
			max_rs_ff <= RS_W'(MAX_RS_RESET);
			sw_level_ff <= 1'b0;
		end else if (reg_wr) begin
			if (hit_filter)
				filt_ff <= reg_wdata[FILT_W-1:0];
			if (hit_ack_to)
				ack_to_ff <= reg_wdata[TO_W-1:0];
			if (hit_max_rs)
				max_rs_ff <= reg_wdata[RS_W-1:0];
			if (hit_level)
				sw_level_ff <= reg_wdata[0];
		end
	end

	// ----------------------------------------
	// source selection and edge detection
	// ----------------------------------------
	logic ext_level;

	htt_line_cond #(
		.SEL_W(SEL_W),
		.FILT_W(FILT_W)
	) u_line (
		.clock(clock),
		.rst_n(rst_n),
		.lines(gpio_lines),
		.line_sel(line_sel_ff),
		.invert(inv_ff),
		.strength(filt_ff),
		.level(ext_level)
	);

	wire logic use_ctrl = src_sel_ff == SRC_GRABBER || src_sel_ff == SRC_CAMERA;
	wire logic use_ext = src_sel_ff == SRC_EXTERNAL;
	wire logic use_sw = src_sel_ff == SRC_SOFTWARE;
	wire logic enabled = use_ctrl || use_ext || use_sw;
	wire logic src_level = (use_ctrl & cam_trigger)
		| (use_ext & ext_level)
		| (use_sw & sw_level_ff);

	logic lvl_ff;
	logic lvl_d_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			lvl_ff <= 1'b0;
			lvl_d_ff <= 1'b0;
		end else begin
			lvl_ff <= src_level;
			lvl_d_ff <= lvl_ff;
		end
	end

	wire logic rise = lvl_ff & ~lvl_d_ff;
	wire logic fall = ~lvl_ff & lvl_d_ff;

	// ----------------------------------------
	// character timing
	// ----------------------------------------
	logic [4:0] phase_ff;
	wire logic char_end = phase_ff == CHAR_LAST;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			phase_ff <= '0;
		else
			phase_ff <= char_end ? 5'h00 : phase_ff + 5'h01;
	end

	// ----------------------------------------
	// transaction state machine
	// ----------------------------------------
	htt_state_t state_ff;
	htt_state_t nxt_state;
	logic [3:0] chars_ff;
	logic [7:0] delay_ff;
	logic falling_ff;
	logic toggle_ff;
	logic [RS_W-1:0] rs_cnt_ff;
	logic [5:0] pre_ff;
	logic [TO_W-1:0] us_ff;
	logic last_abort_ff;

	wire logic idle = state_ff == ST_IDLE;
	wire logic fmt_pulse = fmt_ff == FMT_PULSE;
	wire logic fmt_toggle = fmt_ff == FMT_TOGGLE;
	wire logic fmt_valid = fmt_ff != 2'h3;
	wire logic edge_ok = (rise & fmt_valid) | (fall & fmt_pulse);
	wire logic start = idle & enabled & edge_ok;
	wire logic start_fall = (fmt_pulse & fall) | (fmt_toggle & toggle_ff);
	wire logic pipe_done = state_ff == ST_PIPE && char_end && chars_ff == PIPE_LAST;
	wire logic send_done = state_ff == ST_SEND && char_end && chars_ff == MSG_LAST;
	wire logic no_ack_check = ack_to_ff == '0;
	wire logic us_tick = pre_ff == US_LAST;
	wire logic timed_out = us_ff == ack_to_ff;
	wire logic in_wait = state_ff == ST_WAIT;
	wire logic got_ack = in_wait & ack_in;
	wire logic expire = in_wait & ~ack_in & timed_out;
	wire logic can_resend = rs_cnt_ff < max_rs_ff;
	wire logic resend = expire & can_resend;
	wire logic abort = expire & ~can_resend;

	always_comb begin
		nxt_state = state_ff;
		unique case (state_ff)
			ST_IDLE: begin
				if (start)
					nxt_state = ST_ALIGN;
			end
			ST_ALIGN: begin
				if (char_end)
					nxt_state = ST_PIPE;
			end
			ST_PIPE: begin
				if (pipe_done)
					nxt_state = ST_SEND;
			end
			ST_SEND: begin
				if (send_done)
					nxt_state = no_ack_check ? ST_IDLE : ST_WAIT;
			end
			ST_WAIT: begin
				if (got_ack || abort)
					nxt_state = ST_IDLE;
				else if (resend)
					nxt_state = ST_ALIGN;
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			state_ff <= ST_IDLE;
		else
			state_ff <= nxt_state;
	end

	// character counter across pipeline and message
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			chars_ff <= '0;
		else if (state_ff == ST_ALIGN || pipe_done || send_done)
			chars_ff <= '0;
		else if (char_end)
			chars_ff <= chars_ff + 4'h1;
	end

	// fine delay: cycles from edge to boundary in 2 ns units, kept on resend
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			delay_ff <= '0;
			falling_ff <= 1'b0;
		end else if (start) begin
			delay_ff <= FINE_STEP;
			falling_ff <= start_fall;
		end else if (state_ff == ST_ALIGN && rs_cnt_ff == '0 && !char_end) begin
			delay_ff <= delay_ff + FINE_STEP;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			toggle_ff <= 1'b0;
		else if (start && fmt_toggle)
			toggle_ff <= ~toggle_ff;
	end

	// resend counter
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			rs_cnt_ff <= '0;
		else if (start)
			rs_cnt_ff <= '0;
		else if (resend)
			rs_cnt_ff <= rs_cnt_ff + 1'b1;
	end

	// acknowledge timer in microseconds
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pre_ff <= '0;
			us_ff <= '0;
		end else if (!in_wait) begin
			pre_ff <= '0;
			us_ff <= '0;
		end else if (us_tick) begin
			pre_ff <= '0;
			us_ff <= us_ff + 1'b1;
		end else begin
			pre_ff <= pre_ff + 6'h01;
		end
	end

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			last_abort_ff <= 1'b0;
		else if (abort)
			last_abort_ff <= 1'b1;
		else if (start)
			last_abort_ff <= 1'b0;
	end

	// ----------------------------------------
	// packet and event outputs
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			pkt <= '0;
			ack_received_event <= 1'b0;
			packet_resent_event <= 1'b0;
			transaction_abort_event <= 1'b0;
			busy <= 1'b0;
		end else begin
			pkt.start <= pipe_done;
			pkt.active <= nxt_state == ST_SEND;
			pkt.falling <= pipe_done ? falling_ff : pkt.falling;
			pkt.delay <= pipe_done ? delay_ff : pkt.delay;
			ack_received_event <= got_ack;
			packet_resent_event <= resend;
			transaction_abort_event <= abort;
			busy <= nxt_state != ST_IDLE;
		end
	end

	// event counters, wrapping
	logic [15:0] ack_cnt_ff;
	logic [15:0] rs_tot_ff;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			ack_cnt_ff <= '0;
			rs_tot_ff <= '0;
		end else begin
			if (got_ack)
				ack_cnt_ff <= ack_cnt_ff + 16'h0001;
			if (resend)
				rs_tot_ff <= rs_tot_ff + 16'h0001;
		end
	end

	// ----------------------------------------
	// register read
	// ----------------------------------------
	wire logic [31:0] rd_ctrl = {20'h00000, line_sel_ff[3:0], 1'b0, inv_ff, fmt_ff,
		1'b0, src_sel_ff};
	wire logic [31:0] rd_status = {16'h0000, DEV_ID, rs_cnt_ff, 1'b0, last_abort_ff,
		lvl_ff, ~idle};
	wire logic [31:0] rd_data =
		hit_ctrl ? rd_ctrl :
		hit_filter ? 32'(filt_ff) :
		hit_ack_to ? 32'(ack_to_ff) :
		hit_max_rs ? 32'(max_rs_ff) :
		hit_status ? rd_status :
		hit_level ? {31'h00000000, lvl_ff} :
		hit_evcnt ? {rs_tot_ff, ack_cnt_ff} :
		32'h00000000;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n)
			reg_rdata <= '0;
		else
			reg_rdata <= reg_rd ? rd_data : 32'h00000000;
	end

endmodule

// ===== rtl/htt_pkg.sv
// htt_pkg: constants, register map and types of the trigger transmitter
// assumes a 50 MHz clock and the 20.833 Mbps low-speed upconnection
package htt_pkg;

	// ----------------------------------------
	// clock and link timing
	// ----------------------------------------
	localparam int CLK_PERIOD_NS = 20;
	localparam int CHAR_TIME_NS = 480;
	localparam int FINE_UNIT_NS = 2;
	localparam int US_NS = 1000;
	localparam int CHAR_CYC = CHAR_TIME_NS / CLK_PERIOD_NS;
	localparam int FINE_PER_CYC = CLK_PERIOD_NS / FINE_UNIT_NS;
	localparam int US_CYC = US_NS / CLK_PERIOD_NS;
	localparam int PIPE_CHARS = 4;
	localparam int MSG_CHARS = 6;

	// ----------------------------------------
	// register offsets
	// ----------------------------------------
	localparam logic [7:0] REG_CTRL = 8'h00;
	localparam logic [7:0] REG_FILTER = 8'h04;
	localparam logic [7:0] REG_ACK_TO = 8'h08;
	localparam logic [7:0] REG_MAX_RS = 8'h0C;
	localparam logic [7:0] REG_STATUS = 8'h10;
	localparam logic [7:0] REG_LEVEL = 8'h14;
	localparam logic [7:0] REG_EVCNT = 8'h18;

	// ----------------------------------------
	// control fields
	// ----------------------------------------
	localparam int CTRL_SRC_LSB = 0;
	localparam int CTRL_FMT_LSB = 4;
	localparam int CTRL_INV_BIT = 6;
	localparam int CTRL_LSEL_LSB = 8;

	// ----------------------------------------
	// reset values
	// ----------------------------------------
	localparam logic [15:0] ACK_TO_RESET = 16'h0014;
	localparam logic [7:0] MAX_RS_RESET = 8'h03;
	localparam logic [7:0] FILTER_RESET = 8'h00;

	typedef enum logic [2:0] {
		SRC_NONE = 3'h0,
		SRC_GRABBER = 3'h1,
		SRC_CAMERA = 3'h2,
		SRC_EXTERNAL = 3'h3,
		SRC_SOFTWARE = 3'h4
	} htt_src_t;

	typedef enum logic [1:0] {
		FMT_PULSE = 2'h0,
		FMT_RISING = 2'h1,
		FMT_TOGGLE = 2'h2
	} htt_fmt_t;

	typedef enum logic [2:0] {
		ST_IDLE = 3'b000,
		ST_ALIGN = 3'b001,
		ST_PIPE = 3'b011,
		ST_SEND = 3'b010,
		ST_WAIT = 3'b110
	} htt_state_t;

	// trigger packet towards the upconnection inserter
	typedef struct packed {
		logic start;
		logic active;
		logic falling;
		logic [7:0] delay;
	} htt_pkt_t;

endpackage

// ===== rtl/htt_line_cond.sv
// htt_line_cond: synchronises the general-purpose lines, picks one,
// applies the polarity inverter and the glitch-removal filter
// assumes the lines are asynchronous pins
`timescale 1ns/1ps
module htt_line_cond #(
	parameter int SEL_W = 4,
	parameter int FILT_W = 8
) (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// lines and settings
	input wire logic [(1<<SEL_W)-1:0] lines,
	input wire logic [SEL_W-1:0] line_sel,
	input wire logic invert,
	input wire logic [FILT_W-1:0] strength,
	// conditioned level
	output logic level
);
	logic [(1<<SEL_W)-1:0] meta_ff;
	logic [(1<<SEL_W)-1:0] sync_ff;
	logic [FILT_W-1:0] cnt_ff;
	logic level_ff;
	wire logic picked = sync_ff[line_sel] ^ invert;
	wire logic differs = picked != level_ff;
	wire logic settled = cnt_ff == strength;

	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			meta_ff <= '0;
			sync_ff <= '0;
		end else begin
			meta_ff <= lines;
			sync_ff <= meta_ff;
		end
	end

	// ----------------------------------------
	// filter: new level must hold strength+1 cycles
	// ----------------------------------------
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			cnt_ff <= '0;
			level_ff <= 1'b0;
		end else if (!differs) begin
			cnt_ff <= '0;
		end else if (settled) begin
			cnt_ff <= '0;
			level_ff <= picked;
		end else begin
			cnt_ff <= cnt_ff + 1'b1;
		end
	end

	assign level = level_ff;
endmodule

// ===== testbench/htt_trigger_tx_chk.sv
// htt_trigger_tx_chk: port-level checks of the trigger transmitter
// assumes one clock domain and the register and packet timing of the block
`timescale 1ns/1ps
module htt_trigger_tx_chk import htt_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// watched ports
	input wire logic reg_rd,
	input wire logic [31:0] reg_rdata,
	input wire logic ack_in,
	input wire htt_pkt_t pkt,
	input wire logic ack_received_event,
	input wire logic packet_resent_event,
	input wire logic transaction_abort_event,
	input wire logic busy
);
	// ----------------------------------------
	// helpers and properties
	// ----------------------------------------
	logic [7:0] act_cnt_ff;
	wire logic [7:0] nxt_act_cnt = pkt.active ? act_cnt_ff + 8'h01 : 8'h00;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) act_cnt_ff <= 8'h00;
		else act_cnt_ff <= nxt_act_cnt;
	end
	default clocking @(posedge clock); endclocking
	default disable iff (!rst_n);
	sequence s_realign;
		##[90:130] pkt.start;
	endsequence
	sequence s_one_start;
		pkt.active ##1 (pkt.active && !pkt.start);
	endsequence
	a_start_once: assert property (pkt.start |-> s_one_start)
		else $error("start pulse not a single message opening");
	a_msg_length: assert property ($fell(pkt.active) |-> act_cnt_ff == 8'h90)
		else $error("message not six characters long");
	a_active_busy: assert property (pkt.active |-> busy)
		else $error("message sent while not busy");
	a_ack_cause: assert property (ack_received_event |-> $past(ack_in) && !$past(pkt.active))
		else $error("ack event without accepted ack");
	a_event_alone: assert property ($onehot0({ack_received_event, packet_resent_event,
		transaction_abort_event}))
		else $error("two transaction events at once");
	a_resend_again: assert property (packet_resent_event |-> busy throughout s_realign)
		else $error("resend not followed by a new packet");
	a_abort_cause: assert property (transaction_abort_event |-> $past(busy) && !pkt.active)
		else $error("abort outside a waiting transaction");
	a_packet_held: assert property (!pkt.start |-> $stable({pkt.falling, pkt.delay}))
		else $error("packet fields changed without a start");
	a_delay_units: assert property (pkt.start |-> pkt.delay inside {[8'h0A:8'hF0]}
		&& pkt.delay % 8'h0A == 8'h00)
		else $error("fine delay outside one character");
	a_rdata_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0)
		else $error("read data without a read");
endmodule
bind htt_trigger_tx htt_trigger_tx_chk u_chk (.clock(clock), .rst_n(rst_n), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .ack_in(ack_in), .pkt(pkt), .ack_received_event(ack_received_event),
	.packet_resent_event(packet_resent_event),
	.transaction_abort_event(transaction_abort_event), .busy(busy));

// ===== testbench/htt_cam_model.sv
// htt_cam_model: camera side of the trigger link, acknowledging packets
// assumes ack_in is a one-cycle pulse on the transmitter clock
`timescale 1ns/1ps
module htt_cam_model import htt_pkg::*; (
	// clock and reset
	input wire logic clock,
	input wire logic rst_n,
	// link and behaviour
	input wire htt_pkt_t pkt,
	input wire logic [7:0] lat,
	input wire logic [1:0] miss,
	output logic ack_in
);
	// ----------------------------------------
	// answer after lat cycles, dropping miss packets first
	// ----------------------------------------
	logic act_ff;
	logic pend_ff;
	logic [7:0] cnt_ff;
	logic [1:0] seen_ff;
	always_ff @(posedge clock or negedge rst_n) begin
		if (!rst_n) begin
			act_ff <= 1'b0;
			pend_ff <= 1'b0;
			cnt_ff <= 8'h00;
			seen_ff <= 2'h0;
			ack_in <= 1'b0;
		end else begin
			act_ff <= pkt.active;
			ack_in <= 1'b0;
			if (act_ff && !pkt.active) begin
				if (seen_ff >= miss) begin
					pend_ff <= 1'b1;
					cnt_ff <= lat;
				end else seen_ff <= seen_ff + 2'h1;
			end else if (pend_ff) begin
				if (cnt_ff == 8'h00) begin
					ack_in <= 1'b1;
					pend_ff <= 1'b0;
					seen_ff <= 2'h0;
				end else cnt_ff <= cnt_ff - 8'h01;
			end
		end
	end
endmodule

// ===== testbench/htt_trigger_tx_test.sv
// htt_trigger_tx_test: self-checking bench of one trigger transmitter
// assumes the camera model on the link and the checker bound to the design
`timescale 1ns/1ps
module htt_trigger_tx_test import htt_pkg::*;;
	// ----------------------------------------
	// signals and instances
	// ----------------------------------------
	logic clock = 1'b0;
	logic rst_n = 1'b0;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	logic cam_trigger = 1'b0;
	logic [15:0] gpio_lines = 16'hFFFF;
	logic ack_in;
	htt_pkt_t pkt;
	logic ack_ev, rs_ev, ab_ev, busy;
	logic [31:0] seed = 32'h00004213;
	logic sel_v = 1'b1;
	logic [3:0] lsel = 4'h0;
	logic [7:0] lat = 8'h05;
	logic [1:0] miss = 2'h0;
	logic [8:0] k0 = 9'h000;
	logic again = 1'b0;
	htt_src_t src = SRC_CAMERA;
	int n_errors = 0;
	int checks_done = 0;
	int n_st = 0, n_ack = 0, n_rs = 0, n_ab = 0, lat_ref = -1, to_us = 0, k = 0;
	htt_trigger_tx uut (.clock(clock), .rst_n(rst_n), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .cam_trigger(cam_trigger),
		.gpio_lines(gpio_lines), .ack_in(ack_in), .pkt(pkt), .ack_received_event(ack_ev),
		.packet_resent_event(rs_ev), .transaction_abort_event(ab_ev), .busy(busy));
	htt_cam_model cam (.clock(clock), .rst_n(rst_n), .pkt(pkt), .lat(lat), .miss(miss),
		.ack_in(ack_in));
	initial forever #10 clock = ~clock;
	// ----------------------------------------
	// helpers
	// ----------------------------------------
	function automatic logic [31:0] xs(input logic [31:0] x);
		x = x ^ (x << 13);
		x = x ^ (x >> 17);
		return x ^ (x << 5);
	endfunction
	function automatic logic toggle_fall(input int f, input int i);
		return f == 2 && i % 2 == 1;
	endfunction
	always @(posedge clock) begin
		seed <= xs(seed);
		gpio_lines <= (seed[15:0] & ~(16'h0001 << lsel)) | ({15'h0000, sel_v} << lsel);
		if (pkt.start && again) chk("resent packet", 32'(k0), 32'({pkt.falling, pkt.delay}));
		if (pkt.start) k0 = {pkt.falling, pkt.delay};
		again = pkt.start ? 1'b0 : (again | rs_ev);
		n_st += pkt.start;
		n_ack += ack_ev;
		n_rs += rs_ev;
		n_ab += ab_ev;
	end
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
		checks_done++;
		if (s !== e) begin
			n_errors++;
			$display("Error %s: expected %h, seen %h", nm, e, s);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic rchk(input logic [7:0] a, input logic [31:0] e);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 chk($sformatf("register %h", a), e, reg_rdata);
	endtask
	task automatic cfg(input htt_src_t s, input htt_fmt_t f, input int t, input logic [7:0] m);
		src = s;
		to_us = t;
		lat_ref = -1;
		wr(REG_CTRL, {20'h00000, lsel, 1'b0, 1'b1, f, 1'b0, s});
		wr(REG_ACK_TO, 32'(t));
		wr(REG_MAX_RS, {24'h000000, m});
	endtask
	task automatic trig(input logic v, input logic go, input logic fall);
		int d;
		if (src == SRC_SOFTWARE) wr(REG_LEVEL, 32'(v));
		else begin
			@(posedge clock);
			cam_trigger <= v;
			sel_v <= ~v;
		end
		for (d = 0; d < 400 && pkt.start !== 1'b1; d++) @(posedge clock);
		chk("transaction start", 32'(go), 32'(d < 400));
		if (d < 400) begin
			chk("packet edge", 32'(fall), 32'(pkt.falling));
			chk("delay units", 32'h0, 32'(pkt.delay % 8'h0A));
			if (lat_ref < 0) lat_ref = d - pkt.delay / 10;
			chk("fixed latency", lat_ref, d - pkt.delay / 10);
			for (d = 0; d < 3000 && busy !== 1'b0; d++) @(posedge clock);
			if (to_us == 0) chk("busy length", 32'h00000090, d);
		end
		repeat (3) @(posedge clock);
	endtask
	task automatic ev(input int a, input int r, input int b);
		#1 chk("ack events", a, n_ack);
		chk("resend events", r, n_rs);
		chk("abort events", b, n_ab);
	endtask
	task automatic stop_test;
		$display("checks %0d, mismatches %0d", checks_done, n_errors);
		if (n_errors == 0 && checks_done > 0) $display("SIMULATION PASSED");
		else $display("SIMULATION FAILED");
		$finish;
	endtask
	// ----------------------------------------
	// tests
	// ----------------------------------------
	initial begin
		repeat (60000) @(posedge clock);
		n_errors++;
		$display("Error watchdog: expected end of tests, seen hang");
		stop_test;
	end
	initial begin
		repeat (20) @(posedge clock);
		rst_n <= 1'b1;
		rchk(REG_CTRL, 32'h0);
		rchk(REG_ACK_TO, 32'h14);
		rchk(REG_MAX_RS, 32'h3);
		rchk(REG_FILTER, 32'h0);
		rchk(REG_LEVEL, 32'h0);
		rchk(8'h1C, 32'h0);
		wr(REG_EVCNT, 32'hFFFFFFFF);
		rchk(REG_EVCNT, 32'h0);
		trig(1'b1, 1'b0, 1'b0);
		trig(1'b0, 1'b0, 1'b0);
		$display("test defaults done");
		for (int f = 0; f < 3; f++) begin
			cfg(SRC_CAMERA, htt_fmt_t'(f), 0, 8'h03);
			for (int i = 0; i < 3; i++) begin
				trig(1'b1, 1'b1, toggle_fall(f, i));
				trig(1'b0, f == 0, f == 0);
			end
			$display("test format %0d done", f);
		end
		cfg(SRC_GRABBER, FMT_RISING, 0, 8'h03);
		k = n_st;
		cam_trigger <= 1'b1;
		repeat (3) begin
			repeat (20) @(posedge clock);
			cam_trigger <= 1'b0;
			repeat (20) @(posedge clock);
			cam_trigger <= 1'b1;
		end
		repeat (600) @(posedge clock);
		chk("transactions while busy", k + 1, n_st);
		trig(1'b0, 1'b0, 1'b0);
		$display("test busy done");
		cfg(SRC_CAMERA, htt_fmt_t'(2'h3), 0, 8'h03);
		trig(1'b1, 1'b0, 1'b0);
		trig(1'b0, 1'b0, 1'b0);
		cfg(SRC_CAMERA, FMT_RISING, 1, 8'h02);
		trig(1'b1, 1'b1, 1'b0);
		ev(1, 0, 0);
		trig(1'b0, 1'b0, 1'b0);
		lat <= 8'h28;
		miss <= 2'h1;
		trig(1'b1, 1'b1, 1'b0);
		ev(2, 1, 0);
		trig(1'b0, 1'b0, 1'b0);
		miss <= 2'h3;
		trig(1'b1, 1'b1, 1'b0);
		ev(2, 3, 1);
		rchk(REG_STATUS, 32'h00000026);
		rchk(REG_EVCNT, {16'h0003, 16'h0002});
		$display("test acknowledge done");
		lsel <= seed[3:0];
		sel_v <= 1'b1;
		wr(REG_FILTER, 32'h4);
		cfg(SRC_EXTERNAL, FMT_RISING, 0, 8'h03);
		k = n_st;
		sel_v <= 1'b0;
		repeat (3) @(posedge clock);
		sel_v <= 1'b1;
		repeat (300) @(posedge clock);
		chk("glitch filtered", k, n_st);
		trig(1'b1, 1'b1, 1'b0);
		trig(1'b0, 1'b0, 1'b0);
		$display("test external done");
		cfg(SRC_SOFTWARE, FMT_PULSE, 0, 8'h03);
		trig(1'b1, 1'b1, 1'b0);
		rchk(REG_LEVEL, 32'h1);
		trig(1'b0, 1'b1, 1'b1);
		rchk(REG_LEVEL, 32'h0);
		$display("test software level done");
		stop_test;
	end
endmodule
